// file: logic/fom_pkg.sv
// Shared constants and carriers for the file/offset register mapper
`default_nettype none
package fom_pkg;
    localparam int unsigned FILE_W          = 8;
    localparam int unsigned OFS_W           = 11;
    localparam int unsigned REG_W           = 11;
    localparam int unsigned CNT_W           = 11;
    localparam int unsigned DATA_W          = 16;
    localparam int unsigned ENT_W           = 5;
    localparam logic [FILE_W-1:0] FIRST_REGISTER_FILE = 8'h0a;
    localparam logic [FILE_W-1:0] LAST_REGISTER_FILE  = 8'h18;
    localparam logic [FILE_W-1:0] BULK_ASSEMBLY_FILE  = 8'h32;
    localparam logic [REG_W-1:0]  FILE_STRIDE   = 11'h064;
    localparam logic [REG_W-1:0]  REG_MIN       = 11'h001;
    localparam logic [REG_W-1:0]  REG_MAX       = 11'h5cd;
    localparam logic [OFS_W-1:0]  OFS_MAX       = 11'h5cd;
    localparam logic [CNT_W-1:0]  BULK_ENTRIES  = 11'h020;

    typedef enum logic [1:0] {
        FOM_ERR_NONE,
        FOM_ERR_FILE,
        FOM_ERR_RANGE,
        FOM_ERR_BUSY
    } fom_err_t;

    typedef struct packed {
        logic              write;
        logic [FILE_W-1:0] file_num;
        logic [OFS_W-1:0]  offset;
        logic [CNT_W-1:0]  count;
    } fom_req_t;

    typedef struct packed {
        logic [REG_W-1:0]  reg_addr;
        logic              write;
        logic [DATA_W-1:0] wdata;
    } fom_acc_t;
endpackage
`default_nettype wire

// file: logic/fom_addr_calc.sv
// Start register and range check for one request
`timescale 1ns/1ps
`default_nettype none
module fom_addr_calc
    import fom_pkg::*;
(
    // Request
    input  wire fom_req_t          req,
    // Result
    output logic                   bulk,
    output logic [REG_W-1:0]       start_reg,
    output fom_err_t               err
);
    logic [12:0] lin;
    logic [12:0] last;
    always_comb begin
        bulk = (req.file_num == BULK_ASSEMBLY_FILE);
        lin = 13'(13'(req.file_num - FIRST_REGISTER_FILE) * 13'(FILE_STRIDE))
              + 13'(req.offset);
        start_reg = bulk ? REG_W'(req.offset) : lin[REG_W-1:0];
        last = (bulk ? 13'(req.offset) : lin) + 13'(req.count) - 13'h0001;
        err = FOM_ERR_NONE;
        if (bulk) begin
            // Range reaches at most 32 minus the starting entry
            if (req.offset >= OFS_W'(BULK_ENTRIES) || req.count == '0 ||
                last >= 13'(BULK_ENTRIES)) begin
                err = FOM_ERR_RANGE;
            end
        end else if (req.file_num < FIRST_REGISTER_FILE ||
                     req.file_num > LAST_REGISTER_FILE) begin
            err = FOM_ERR_FILE;
        end else if (req.offset > OFS_MAX || req.count == '0 ||
                     lin < 13'(REG_MIN) || last > 13'(REG_MAX)) begin
            err = FOM_ERR_RANGE;
        end
    end
endmodule
`default_nettype wire

// file: logic/fom_mapper.sv
// Typed read/write dispatcher mapping file/offset requests to drive registers
// What this block does
// - Typed reads read registers; typed writes write registers.
// - Ordinary target register is (file minus 10) times 100 plus offset.
// - Files 10 to 24 and bulk file 50 only; target 1..1485; offset at most 1485.
// - File/offset pairs with the same target reach the same register.
// - Bulk file reads follow the produced configuration array order.
// - Bulk file writes go to registers named by the consumed array.
// - Bulk offset must be 0 to 31, selecting the starting entry.
// - Bulk access reaches at most 32 minus start offset elements.
// - Access count consecutive items starting at the computed start.
// - Connection timeout or socket error raises the timeout event.
`timescale 1ns/1ps
`default_nettype none
module fom_mapper
    import fom_pkg::*;
#(
    parameter int unsigned ENTRIES = 32
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Request from protocol handler
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire fom_req_t          req,
    // Write data stream, one word per element
    input  wire logic              wdata_valid,
    output logic                   wdata_ready,
    input  wire logic [DATA_W-1:0] wdata,
    // Read data stream, one word per element
    output logic                   rdata_valid,
    output logic [DATA_W-1:0]      rdata,
    // Completion
    output logic                   done,
    output fom_err_t               done_err,
    // Configuration arrays, flattened, entry 0 in low bits
    input  wire logic [ENTRIES*REG_W-1:0] produced_map,
    input  wire logic [ENTRIES*REG_W-1:0] consumed_map,
    // Drive register port
    output logic                   acc_valid,
    output fom_acc_t               acc,
    input  wire logic [DATA_W-1:0] acc_rdata,
    // Link events
    input  wire logic              conn_timeout,
    input  wire logic              sock_error,
    output logic                   timeout_event
);
    // ==================================================================
    // State
    typedef enum logic [1:0] {S_IDLE, S_RUN, S_RDWAIT, S_DONE} fom_state_t;
    fom_state_t       state_q;
    logic             bulk, bulk_q, write_q;
    logic [REG_W-1:0] start_reg, ptr_q;
    logic [CNT_W-1:0] left_q;
    fom_err_t         err, err_q;
    logic [REG_W-1:0] target;
    logic             step;

    fom_addr_calc u_calc (
        .req       (req),
        .bulk      (bulk),
        .start_reg (start_reg),
        .err       (err)
    );

    // ==================================================================
    // Address selection
    always_comb begin
        target = ptr_q;
        if (bulk_q) begin
            target = write_q ? consumed_map[ptr_q[ENT_W-1:0]*REG_W +: REG_W]
                             : produced_map[ptr_q[ENT_W-1:0]*REG_W +: REG_W];
        end
    end

    assign req_ready   = (state_q == S_IDLE);
    assign step        = (state_q == S_RUN) && (!write_q || wdata_valid);
    assign wdata_ready = (state_q == S_RUN) && write_q;
    assign acc_valid   = step;
    // One driver for the whole carrier keeps the struct single-sourced
    assign acc         = '{reg_addr: target, write: write_q,
                           wdata: wdata};

    // ==================================================================
    // Sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            bulk_q  <= 1'b0;
            write_q <= 1'b0;
            ptr_q   <= '0;
            left_q  <= '0;
            err_q   <= FOM_ERR_NONE;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (req_valid) begin
                        bulk_q  <= bulk;
                        write_q <= req.write;
                        ptr_q   <= start_reg;
                        left_q  <= req.count;
                        err_q   <= err;
                        // Rejected requests skip straight to completion
                        state_q <= (err == FOM_ERR_NONE) ? S_RUN
                                                         : S_DONE;
                    end
                end
                S_RUN: begin
                    if (step) begin
                        ptr_q   <= ptr_q + 11'h001;
                        left_q  <= left_q - 11'h001;
                        if (!write_q) begin
                            state_q <= S_RDWAIT;
                        end else if (left_q == 11'h001) begin
                            state_q <= S_DONE;
                        end
                    end
                end
                S_RDWAIT: begin
                    // Drive registers answer one cycle after the access
                    state_q <= (left_q == '0) ? S_DONE : S_RUN;
                end
                S_DONE: state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ==================================================================
    // Read data and completion outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_valid <= 1'b0;
            rdata       <= '0;
        end else begin
            rdata_valid <= (state_q == S_RDWAIT);
            if (state_q == S_RDWAIT) begin
                rdata <= acc_rdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done     <= 1'b0;
            done_err <= FOM_ERR_NONE;
        end else begin
            done     <= (state_q == S_DONE);
            done_err <= (state_q == S_DONE) ? err_q : FOM_ERR_NONE;
        end
    end

    // ==================================================================
    // Timeout event, one pulse per link fault cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timeout_event <= 1'b0;
        end else begin
            timeout_event <= conn_timeout | sock_error;
        end
    end

    // ==================================================================
    // Access tally, checked against the requested count at completion
    logic [CNT_W-1:0] tally_q;
    logic [CNT_W-1:0] want_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tally_q <= '0;
            want_q  <= '0;
        end else if (req_valid && req_ready) begin
            tally_q <= '0;
            want_q  <= (err == FOM_ERR_NONE) ? req.count : '0;
        end else if (acc_valid) begin
            tally_q <= tally_q + 11'h001;
        end
    end

    // ==================================================================
    // Assertions
    a_timeout_event: assert property (
        @(posedge clk) disable iff (rst)
        (conn_timeout | sock_error) |=> timeout_event)
        else $error("timeout event missing");
    a_bad_file_err: assert property (
        @(posedge clk) disable iff (rst)
        (req_valid && req_ready && !bulk &&
         (req.file_num < FIRST_REGISTER_FILE ||
          req.file_num > LAST_REGISTER_FILE))
        |-> ##2 (done && done_err == FOM_ERR_FILE))
        else $error("bad file not rejected");
    a_bad_file_noacc: assert property (
        @(posedge clk) disable iff (rst)
        (req_valid && req_ready && err != FOM_ERR_NONE)
        |=> !acc_valid [*2])
        else $error("access on rejected request");
    a_first_addr: assert property (
        @(posedge clk) disable iff (rst)
        (req_valid && req_ready && !bulk && err == FOM_ERR_NONE)
        |=> acc.reg_addr == REG_W'(
            (int'($past(req.file_num)) - int'(FIRST_REGISTER_FILE)) *
            int'(FILE_STRIDE) + int'($past(req.offset))))
        else $error("wrong start register");
    a_bulk_range: assert property (
        @(posedge clk) disable iff (rst)
        (req_valid && req_ready && bulk && req.offset > 11'h01f)
        |-> err == FOM_ERR_RANGE)
        else $error("bulk offset accepted");
    a_bulk_count: assert property (
        @(posedge clk) disable iff (rst)
        (req_valid && req_ready && bulk &&
         13'(req.offset) + 13'(req.count) > 13'h0020)
        |-> err != FOM_ERR_NONE)
        else $error("bulk count too large");
    a_bulk_map: assert property (
        @(posedge clk) disable iff (rst)
        (req_valid && req_ready && bulk && !req.write &&
         err == FOM_ERR_NONE)
        |=> acc.reg_addr ==
            produced_map[$past(req.offset[ENT_W-1:0]) * REG_W +: REG_W])
        else $error("bulk read not mapped");
    a_bulk_wmap: assert property (
        @(posedge clk) disable iff (rst)
        (req_valid && req_ready && bulk && req.write &&
         err == FOM_ERR_NONE)
        |=> acc.reg_addr ==
            consumed_map[$past(req.offset[ENT_W-1:0]) * REG_W +: REG_W])
        else $error("bulk write not mapped");
    a_step_incr: assert property (
        @(posedge clk) disable iff (rst)
        (acc_valid && !bulk_q && left_q > 11'h001)
        |-> ##[1:2] (ptr_q == $past(ptr_q) + 11'h001))
        else $error("pointer not consecutive");
    a_read_data: assert property (
        @(posedge clk) disable iff (rst)
        (acc_valid && !write_q) |=> ##1 rdata_valid)
        else $error("read data missing");
    a_read_word: assert property (
        @(posedge clk) disable iff (rst)
        (acc_valid && !write_q) |=> ##1 (rdata == $past(acc_rdata)))
        else $error("read word not passed on");
    a_access_tally: assert property (
        @(posedge clk) disable iff (rst)
        done |-> tally_q == want_q)
        else $error("access count differs from request");
    c_read: cover property (@(posedge clk) rdata_valid && !bulk_q);
    c_write: cover property (@(posedge clk) acc_valid && write_q);
    c_bulk: cover property (@(posedge clk) acc_valid && bulk_q);
    c_error: cover property (@(posedge clk) done && done_err != FOM_ERR_NONE);
endmodule
`default_nettype wire

// file: dv/fom_drive_model.sv
// Behavioural drive register space behind the mapper
`timescale 1ns/1ps
`default_nettype none
module fom_drive_model
    import fom_pkg::*;
(
    // Clock
    input  wire logic         clk,
    // Access port
    input  wire logic         acc_valid,
    input  wire fom_acc_t     acc,
    output logic [DATA_W-1:0] acc_rdata
);
    // ====
    // Storage, seeded with a pattern the bench can predict
    logic [DATA_W-1:0] mem [0:2047];
    initial begin
        for (int i = 0; i < 2048; i++) mem[i] = {5'h15, i[10:0]};
    end
    // Idle cycles toggle the bus so stale data never looks valid
    always @(posedge clk) begin
        if (acc_valid && acc.write) mem[acc.reg_addr] <= acc.wdata;
        acc_rdata <= acc_valid ? mem[acc.reg_addr] : ~acc_rdata;
    end
endmodule
`default_nettype wire

// file: dv/fom_mapper_tb.sv
// Self-checking bench for the file/offset register mapper
`timescale 1ns/1ps
`default_nettype none
module fom_mapper_tb
    import fom_pkg::*;
;
    logic            clk = 1'b0, rst = 1'b1, req_valid = 1'b0;
    logic            wdata_valid = 1'b0, conn_timeout = 1'b0;
    logic            sock_error = 1'b0;
    fom_req_t        req = '0;
    logic [15:0]     wdata = '0;
    logic [351:0]    pmap, cmap;
    logic            req_ready, wdata_ready, rdata_valid, done;
    logic            acc_valid, timeout_event;
    logic [15:0]     rdata, acc_rdata;
    fom_err_t        done_err, eg;
    fom_acc_t        acc;
    logic [15:0]     got [$];
    int              error_cnt = 0, cmp_count = 0;
    always #12.5 clk = ~clk;
    fom_mapper DUT (.clk(clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .wdata_valid(wdata_valid),
        .wdata_ready(wdata_ready), .wdata(wdata), .rdata(rdata),
        .rdata_valid(rdata_valid), .done(done), .done_err(done_err),
        .produced_map(pmap), .consumed_map(cmap), .acc_valid(acc_valid),
        .acc(acc), .acc_rdata(acc_rdata), .conn_timeout(conn_timeout),
        .sock_error(sock_error), .timeout_event(timeout_event));
    fom_drive_model drv (.clk(clk), .acc_valid(acc_valid), .acc(acc),
        .acc_rdata(acc_rdata));
    // ====
    // Helpers
    function automatic logic [10:0] pm(int i);
        return 11'(100 + 3 * i);
    endfunction
    function automatic logic [15:0] iv(logic [10:0] a);
        return {5'h15, a};
    endfunction
    task automatic chk_err(fom_err_t g, fom_err_t e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: code %0d want %0d", $time, g, e);
        end
    endtask
    task automatic chk_word(logic [15:0] g, logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: word %h want %h", $time, g, e);
        end
    endtask
    // Single request in flight; next one only after done
    task automatic run_req(logic w, logic [7:0] f, logic [10:0] o,
                           logic [10:0] n, logic [15:0] wb);
        int k;
        int t;
        k = 0;
        t = 0;
        got.delete();
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{write: w, file_num: f, offset: o, count: n};
        wdata_valid <= w;
        wdata <= wb;
        @(posedge clk);
        req_valid <= 1'b0;
        chk_word(16'(req_ready), 16'h0001);
        while (done !== 1'b1 && t < 300) begin
            @(posedge clk);
            t++;
            if (t == 1) chk_word(16'(req_ready), 16'h0000);
            if (rdata_valid === 1'b1) got.push_back(rdata);
            if (wdata_ready === 1'b1 && w) begin
                k++;
                wdata <= wb + 16'(k);
            end
        end
        wdata_valid <= 1'b0;
        eg = done_err;
        if (t == 300) chk_word(16'h0000, 16'h0001);
    endtask
    task automatic t_one(logic [7:0] f, logic [10:0] o, logic [10:0] n,
                         fom_err_t e);
        run_req(1'b0, f, o, n, '0);
        chk_err(eg, e);
        if (e != FOM_ERR_NONE) chk_word(16'(got.size()), 16'h0000);
    endtask
    // ====
    // Scenarios
    task automatic t_ordinary();
        t_one(8'h0c, 11'h063, 11'h002, FOM_ERR_NONE);
        chk_word(16'(got.size()), 16'h0002);
        for (int k = 0; k < 2; k++) chk_word(got[k], iv(11'(299 + k)));
        t_one(8'h0b, 11'h0c7, 11'h001, FOM_ERR_NONE);
        chk_word(got[0], iv(11'h12b));
        run_req(1'b1, 8'h14, 11'h007, 11'h002, 16'hbe00);
        chk_err(eg, FOM_ERR_NONE);
        t_one(8'h14, 11'h007, 11'h002, FOM_ERR_NONE);
        for (int k = 0; k < 2; k++) chk_word(got[k], 16'hbe00 + 16'(k));
        $display("test ordinary done");
    endtask
    task automatic t_limits();
        t_one(8'h18, 11'h055, 11'h001, FOM_ERR_NONE);
        chk_word(got[0], iv(11'h5cd));
        t_one(8'h0a, 11'h5cd, 11'h001, FOM_ERR_NONE);
        t_one(8'h0a, 11'h000, 11'h001, FOM_ERR_RANGE);
        t_one(8'h09, 11'h001, 11'h001, FOM_ERR_FILE);
        t_one(8'h19, 11'h001, 11'h001, FOM_ERR_FILE);
        t_one(8'h18, 11'h055, 11'h002, FOM_ERR_RANGE);
        t_one(8'h0c, 11'h005, 11'h000, FOM_ERR_RANGE);
        $display("test limits done");
    endtask
    task automatic t_bulk();
        t_one(8'h32, 11'h000, 11'h020, FOM_ERR_NONE);
        for (int k = 0; k < 32; k++) chk_word(got[k], iv(pm(k)));
        t_one(8'h32, 11'h01f, 11'h001, FOM_ERR_NONE);
        chk_word(got[0], iv(pm(31)));
        t_one(8'h32, 11'h01f, 11'h002, FOM_ERR_RANGE);
        t_one(8'h32, 11'h020, 11'h001, FOM_ERR_RANGE);
        run_req(1'b1, 8'h32, 11'h003, 11'h002, 16'hc300);
        chk_err(eg, FOM_ERR_NONE);
        t_one(8'h10, 11'h003, 11'h002, FOM_ERR_NONE);
        for (int k = 0; k < 2; k++) chk_word(got[k], 16'hc300 + 16'(k));
        $display("test bulk done");
    endtask
    task automatic t_link();
        @(posedge clk) conn_timeout <= 1'b1;
        @(posedge clk) conn_timeout <= 1'b0;
        @(posedge clk) sock_error <= 1'b1;
        chk_word(16'(timeout_event), 16'h0001);
        @(posedge clk) sock_error <= 1'b0;
        @(posedge clk) chk_word(16'(timeout_event), 16'h0001);
        repeat (2) @(posedge clk);
        chk_word(16'(timeout_event), 16'h0000);
        $display("test link done");
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ====
    // Sequence and watchdog
    initial begin
        for (int i = 0; i < 32; i++) begin
            pmap[i*11 +: 11] = pm(i);
            cmap[i*11 +: 11] = 11'(600 + i);
        end
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_ordinary();
        t_limits();
        t_bulk();
        t_link();
        print_verdict();
    end
    initial begin
        #200000;
        chk_word(16'h0000, 16'h0001);
        print_verdict();
    end
endmodule
`default_nettype wire
